// ---- rtl/dpllw_ctrl.sv ----
// Control wrapper around a digital loop: control register, lock sequencing,
// bypass and lock dividers, isolation collar and test clock output.
// Assumes i_mclk is the reference clock and the analog core sits outside,
// reporting loss of lock on an asynchronous pin.
`include "dpllw_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module dpllw_ctrl #(
    parameter int unsigned P_STAGES = 5,
    parameter int unsigned P_CNT_W = 11
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic [1:0] i_clock_mode_pins,
    input wire logic i_idle,
    input wire logic i_test_mode,
    input wire logic i_core_lock_lost,
    input wire logic i_ctl_wr,
    input wire logic [15:0] i_ctl_wdata,
    output logic [15:0] o_ctl_rdata,
    output logic o_lock_status,
    output logic o_lock_intact_flag,
    output logic o_clk_tick,
    output logic o_use_synth,
    output logic o_test_clock_out,
    output logic o_core_enable,
    output logic [4:0] o_core_mult,
    output logic [1:0] o_core_div,
    output logic o_isolation_ctrl,
    output dpllw_pkg::dpllw_state_t o_state
);
    import dpllw_pkg::*;

    typedef struct packed {
        logic [15:0] ctl;
        dpllw_state_t st;
        logic [P_CNT_W-1:0] cnt;
        logic intact;
        logic lost;
        logic [4:0] tcnt;
        logic test_clk;
    } dpllw_ctrl_t;

    dpllw_ctrl_t s_ff;
    dpllw_ctrl_t nxt_s;

    logic [4:0] pins_sync;
    logic idle_s;
    logic test_s;
    logic core_lost;
    logic loss_rise;
    logic restored;
    logic div_tick;
    logic [2:0] ratio;
    logic [15:0] rst_ctl;

    // Reset contents picked from the mode pins
    function automatic logic [15:0] mode_default(input logic [1:0] pins);
        logic [15:0] v;
        case (pins)
            2'b00: v = `DPLLW_RST_MODE0;
            2'b01: v = `DPLLW_RST_MODE1;
            2'b10: v = `DPLLW_RST_MODE2;
            default: v = `DPLLW_RST_MODE3;
        endcase
        return v;
    endfunction

    // Lock duration 4N(11D+28) with N the divide ratio and D clamped 1..7
    function automatic logic [P_CNT_W-1:0] lock_cycles(input logic [1:0] div);
        int n;
        int d;
        n = int'(div) + 1;
        d = (P_STAGES > `DPLLW_STAGES_MAX) ? `DPLLW_STAGES_MAX :
            ((P_STAGES < 1) ? 1 : int'(P_STAGES));
        return P_CNT_W'(`DPLLW_LOCK_K4 * n * (`DPLLW_LOCK_K11 * d + `DPLLW_LOCK_K28));
    endfunction

    // Bypass field: 00 by 1, 01 by 2, 1x by 4
    function automatic logic [2:0] bypass_ratio(input logic [1:0] f);
        logic [2:0] r;
        if (f[1]) begin
            r = 3'h4;
        end else if (f[0]) begin
            r = 3'h2;
        end else begin
            r = 3'h1;
        end
        return r;
    endfunction

    dpllw_sync #(
        .P_W(5)
    ) u_sync (
        .i_mclk(i_mclk),
        .i_async({i_clock_mode_pins, i_idle, i_test_mode, i_core_lock_lost}),
        .o_sync(pins_sync)
    );

    assign idle_s = pins_sync[2];
    assign test_s = pins_sync[1];
    // Collar isolated: loss report from the core reads as ground
    assign core_lost = pins_sync[0] & ~s_ff.ctl[`DPLLW_BIT_ISO];
    assign loss_rise = core_lost & ~s_ff.lost;
    assign restored = ~core_lost & s_ff.lost;
    assign rst_ctl = mode_default(pins_sync[4:3]);

    // Lock operation divides by field plus one; every other state divides
    // per the bypass field, so the output never stops while locking.
    always_comb begin
        if (s_ff.st == DPLLW_ST_LOCKED) begin
            ratio = {1'b0, s_ff.ctl[`DPLLW_DIV_MSB:`DPLLW_DIV_LSB]} + 3'h1;
        end else begin
            ratio = bypass_ratio(s_ff.ctl[`DPLLW_BYP_MSB:`DPLLW_BYP_LSB]);
        end
    end

    dpllw_div u_div (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_restart(i_ctl_wr),
        .i_ratio(ratio),
        .o_tick(div_tick)
    );

    always_comb begin
        nxt_s = s_ff;
        nxt_s.lost = core_lost;
        case (s_ff.st)
            DPLLW_ST_BYPASS: begin
                nxt_s.st = DPLLW_ST_BYPASS;
            end
            DPLLW_ST_LOCKING: begin
                // An isolated core cannot lock, so the count waits
                if (!s_ff.ctl[`DPLLW_BIT_ISO]) begin
                    if (s_ff.cnt <= P_CNT_W'(1)) begin
                        nxt_s.st = DPLLW_ST_LOCKED;
                        nxt_s.intact = 1'b1;
                    end else begin
                        nxt_s.cnt = s_ff.cnt - P_CNT_W'(1);
                    end
                end
            end
            DPLLW_ST_LOCKED: begin
                if (loss_rise && s_ff.ctl[`DPLLW_BIT_RESTART]) begin
                    nxt_s.st = DPLLW_ST_LOCKING;
                    nxt_s.cnt = lock_cycles(s_ff.ctl[`DPLLW_DIV_MSB:`DPLLW_DIV_LSB]);
                end else if (restored) begin
                    nxt_s.intact = 1'b1;
                end
            end
            DPLLW_ST_IDLE: begin
                if (!idle_s) begin
                    // Relock from scratch whatever the obsolete relock bit says
                    if (s_ff.ctl[`DPLLW_BIT_ENABLE]) begin
                        nxt_s.st = DPLLW_ST_LOCKING;
                        nxt_s.cnt = lock_cycles(s_ff.ctl[`DPLLW_DIV_MSB:`DPLLW_DIV_LSB]);
                    end else begin
                        nxt_s.st = DPLLW_ST_BYPASS;
                    end
                end
            end
            default: begin
                nxt_s.st = DPLLW_ST_BYPASS;
            end
        endcase

        if (idle_s && s_ff.st != DPLLW_ST_IDLE) begin
            nxt_s.st = DPLLW_ST_IDLE;
        end

        if (i_ctl_wr) begin
            nxt_s.ctl = i_ctl_wdata & `DPLLW_WR_MASK;
            nxt_s.intact = 1'b1;
            if (s_ff.st != DPLLW_ST_IDLE && !idle_s) begin
                if (i_ctl_wdata[`DPLLW_BIT_ENABLE]) begin
                    nxt_s.st = DPLLW_ST_LOCKING;
                    nxt_s.cnt = lock_cycles(i_ctl_wdata[`DPLLW_DIV_MSB:`DPLLW_DIV_LSB]);
                end else begin
                    nxt_s.st = DPLLW_ST_BYPASS;
                end
            end
        end

        // A loss reported in the same cycle as a write is not dropped
        if (loss_rise) begin
            nxt_s.intact = 1'b0;
        end

        nxt_s.test_clk = 1'b0;
        if (div_tick) begin
            nxt_s.tcnt = s_ff.tcnt + 5'h1;
            if (test_s) begin
                nxt_s.test_clk = s_ff.ctl[`DPLLW_BIT_TEST] ? (s_ff.tcnt == 5'h1f) : 1'b1;
            end
        end

        if (!i_resetn) begin
            nxt_s.ctl = rst_ctl;
            nxt_s.st = rst_ctl[`DPLLW_BIT_ENABLE] ?
                DPLLW_ST_LOCKING : DPLLW_ST_BYPASS;
            nxt_s.cnt = lock_cycles(rst_ctl[`DPLLW_DIV_MSB:`DPLLW_DIV_LSB]);
            nxt_s.intact = 1'b0;
            nxt_s.lost = 1'b0;
            nxt_s.tcnt = 5'h0;
            nxt_s.test_clk = 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        s_ff <= nxt_s;
    end

    assign o_state = s_ff.st;
    assign o_lock_status = (s_ff.st == DPLLW_ST_LOCKED);
    assign o_lock_intact_flag = s_ff.intact;
    assign o_ctl_rdata = {s_ff.ctl[15:2], s_ff.intact, o_lock_status};
    // Multiply 0 or 1 leaves the divided reference on the output
    assign o_use_synth = o_lock_status &&
        (s_ff.ctl[`DPLLW_MULT_MSB:`DPLLW_MULT_LSB] > 5'h1);
    assign o_clk_tick = div_tick;
    assign o_test_clock_out = s_ff.test_clk;
    assign o_isolation_ctrl = s_ff.ctl[`DPLLW_BIT_ISO];
    assign o_core_enable = ~s_ff.ctl[`DPLLW_BIT_ISO] &
        ((s_ff.st == DPLLW_ST_LOCKING) | (s_ff.st == DPLLW_ST_LOCKED));
    assign o_core_mult = s_ff.ctl[`DPLLW_BIT_ISO] ? 5'h0 :
        s_ff.ctl[`DPLLW_MULT_MSB:`DPLLW_MULT_LSB];
    assign o_core_div = s_ff.ctl[`DPLLW_BIT_ISO] ? 2'h0 :
        s_ff.ctl[`DPLLW_DIV_MSB:`DPLLW_DIV_LSB];

    sequence s_live_write;
        i_resetn && i_ctl_wr && !idle_s && s_ff.st != DPLLW_ST_IDLE;
    endsequence

    sequence s_quiet_locked;
        s_ff.st == DPLLW_ST_LOCKED && !i_ctl_wr && !idle_s && loss_rise;
    endsequence

    chk_write_bypass: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        s_live_write |=> !o_use_synth && !o_lock_status)
        else $error("write did not force bypass");

    chk_lock_expiry: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (s_ff.st == DPLLW_ST_LOCKING && s_ff.cnt == P_CNT_W'(1) && !i_ctl_wr && !idle_s &&
         !o_isolation_ctrl) |=> o_lock_status)
        else $error("lock count expiry did not reach lock");

    chk_disable_bypass: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (s_live_write and !i_ctl_wdata[`DPLLW_BIT_ENABLE]) ##1 (!i_ctl_wr && !idle_s) |=>
        s_ff.st == DPLLW_ST_BYPASS)
        else $error("cleared lock request left bypass");

    chk_iso_ground: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        o_isolation_ctrl |-> !o_core_enable && o_core_mult == 5'h0 && o_core_div == 2'h0)
        else $error("collar outputs not grounded while isolated");

    chk_loss_restart: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (s_quiet_locked and s_ff.ctl[`DPLLW_BIT_RESTART]) |=>
        s_ff.st == DPLLW_ST_LOCKING && !o_use_synth && !o_lock_intact_flag)
        else $error("loss of lock did not restart locking");

    chk_loss_keep: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (s_quiet_locked and !s_ff.ctl[`DPLLW_BIT_RESTART]) |=>
        o_lock_status && !o_lock_intact_flag)
        else $error("loss of lock with restart off left lock");

    chk_test_off: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        !test_s |=> !o_test_clock_out)
        else $error("test clock active outside test mode");

    chk_bypass_quarter: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (s_ff.st == DPLLW_ST_BYPASS && s_ff.ctl[`DPLLW_BYP_MSB] && o_clk_tick && !i_ctl_wr &&
         !idle_s) |=> !o_clk_tick [*3])
        else $error("bypass quarter rate ticked early");

    chk_write_intact: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (i_ctl_wr && !loss_rise) |=> o_lock_intact_flag)
        else $error("write did not restore intact flag");

    chk_lock_count: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (s_live_write and i_ctl_wdata[`DPLLW_BIT_ENABLE]) |=>
        s_ff.cnt == lock_cycles($past(i_ctl_wdata[`DPLLW_DIV_MSB:`DPLLW_DIV_LSB])) &&
        s_ff.st == DPLLW_ST_LOCKING)
        else $error("lock count not loaded from formula");

    sequence s_lock_request;
        i_resetn && i_ctl_wr && i_ctl_wdata[`DPLLW_BIT_ENABLE] && !idle_s &&
        s_ff.st != DPLLW_ST_IDLE;
    endsequence

    // Checked while reset is low, so it carries no disable clause
    chk_reset_load: assert property (@(posedge i_mclk)
        !i_resetn |=> s_ff.ctl == $past(rst_ctl) && !o_lock_intact_flag && !o_lock_status)
        else $error("reset did not load the mode default");

    chk_request_wait: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        s_lock_request ##1 !i_ctl_wr |=> !o_lock_status && !o_use_synth)
        else $error("lock reported before the lock count ran out");

    chk_idle_write: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (i_ctl_wr && idle_s && s_ff.st == DPLLW_ST_IDLE) |=> s_ff.st == DPLLW_ST_IDLE)
        else $error("write during idle changed the operating state");

    chk_lock_unity: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (s_ff.st == DPLLW_ST_LOCKED && s_ff.ctl[`DPLLW_DIV_MSB:`DPLLW_DIV_LSB] == 2'h0 &&
         !i_ctl_wr) |=> o_clk_tick)
        else $error("lock divide by one did not tick every cycle");

    chk_bypass_unity: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (s_ff.st == DPLLW_ST_BYPASS && s_ff.ctl[`DPLLW_BYP_MSB:`DPLLW_BYP_LSB] == 2'h0 &&
         !i_ctl_wr) |=> o_clk_tick)
        else $error("bypass divide by one did not tick every cycle");

    chk_locking_ref: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (s_ff.st == DPLLW_ST_LOCKING && s_ff.ctl[`DPLLW_BYP_MSB:`DPLLW_BYP_LSB] == 2'h0 &&
         !i_ctl_wr) |=> o_clk_tick)
        else $error("reference output stopped while locking");

    chk_intact_restore: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (s_ff.st == DPLLW_ST_LOCKED && restored) |=> o_lock_intact_flag)
        else $error("restored lock did not raise the intact flag");

    chk_test_follow: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (test_s && !s_ff.ctl[`DPLLW_BIT_TEST] && div_tick) |=> o_test_clock_out)
        else $error("test output did not follow the output clock");

    chk_test_div: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (test_s && s_ff.ctl[`DPLLW_BIT_TEST] && div_tick && s_ff.tcnt != 5'h1f) |=>
        !o_test_clock_out)
        else $error("divided test output pulsed early");
endmodule
`default_nettype wire

// ---- rtl/dpllw_div.sv ----
// Reference divider producing a one-cycle enable every i_ratio cycles.
// Assumes i_ratio is 1 to 4 and restart realigns the phase.
`timescale 1ns/1ns
`default_nettype none
module dpllw_div (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_restart,
    input wire logic [2:0] i_ratio,
    output logic o_tick
);
    typedef struct packed {
        logic [2:0] cnt;
        logic tick;
    } dpllw_div_t;

    dpllw_div_t s_ff;
    dpllw_div_t nxt_s;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.tick = 1'b0;
        if (!i_resetn || i_restart) begin
            nxt_s.cnt = 3'h0;
        end else if (s_ff.cnt >= i_ratio - 3'h1) begin
            nxt_s.cnt = 3'h0;
            nxt_s.tick = 1'b1;
        end else begin
            nxt_s.cnt = s_ff.cnt + 3'h1;
        end
    end

    always_ff @(posedge i_mclk) begin
        s_ff <= nxt_s;
    end

    assign o_tick = s_ff.tick;
endmodule
`default_nettype wire

// ---- rtl/dpllw_pkg.sv ----
// Types shared by the loop control wrapper and its checks.
// Assumes dpllw_regs.svh supplies the numeric constants.
package dpllw_pkg;

    typedef enum logic [1:0] {
        DPLLW_ST_BYPASS = 2'b00,
        DPLLW_ST_LOCKING = 2'b01,
        DPLLW_ST_LOCKED = 2'b10,
        DPLLW_ST_IDLE = 2'b11
    } dpllw_state_t;

endpackage

// ---- rtl/dpllw_regs.svh ----
// Constants for the loop control wrapper: register offset, field positions,
// reset values per mode-pin setting and lock-time terms. Definitions only.
`ifndef DPLLW_REGS_SVH
`define DPLLW_REGS_SVH

`define DPLLW_CTL_OFFSET 8'h00
`define DPLLW_CTL_WIDTH 16
`define DPLLW_WR_MASK 16'hfffc

`define DPLLW_BIT_ISO 15
`define DPLLW_BIT_RELOCK 14
`define DPLLW_BIT_RESTART 13
`define DPLLW_BIT_TEST 12
`define DPLLW_MULT_MSB 11
`define DPLLW_MULT_LSB 7
`define DPLLW_DIV_MSB 6
`define DPLLW_DIV_LSB 5
`define DPLLW_BIT_ENABLE 4
`define DPLLW_BYP_MSB 3
`define DPLLW_BYP_LSB 2
`define DPLLW_BIT_INTACT 1
`define DPLLW_BIT_LOCK 0

// Reset contents selected by the two mode pins
`define DPLLW_RST_MODE0 16'h2000
`define DPLLW_RST_MODE1 16'h2004
`define DPLLW_RST_MODE2 16'h2008
`define DPLLW_RST_MODE3 16'h2110

`define DPLLW_LOCK_K4 4
`define DPLLW_LOCK_K11 11
`define DPLLW_LOCK_K28 28
`define DPLLW_STAGES_MAX 7
`define DPLLW_TEST_DIV 32

`endif

// ---- rtl/dpllw_sync.sv ----
// Three-stage synchroniser for pin inputs; a change is taken once stages
// two and three agree. Assumes a single destination clock.
`timescale 1ns/1ns
`default_nettype none
module dpllw_sync #(
    parameter int unsigned P_W = 1
) (
    input wire logic i_mclk,
    input wire logic [P_W-1:0] i_async,
    output logic [P_W-1:0] o_sync
);
    typedef struct packed {
        logic [P_W-1:0] s1;
        logic [P_W-1:0] s2;
        logic [P_W-1:0] s3;
        logic [P_W-1:0] q;
    } dpllw_sync_t;

    dpllw_sync_t s_ff;
    dpllw_sync_t nxt_s;

    // No reset: the chain settles within four edges, so the owner holds
    // its reset at least that long before trusting the outputs.
    always_comb begin
        nxt_s = s_ff;
        nxt_s.s1 = i_async;
        nxt_s.s2 = s_ff.s1;
        nxt_s.s3 = s_ff.s2;
        for (int i = 0; i < int'(P_W); i++) begin
            if (s_ff.s2[i] == s_ff.s3[i]) begin
                nxt_s.q[i] = s_ff.s3[i];
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        s_ff <= nxt_s;
    end

    assign o_sync = s_ff.q;
endmodule
`default_nettype wire

// ---- testbench/digital_pll_control_wrapper_tb.sv ----
// Self-checking bench for the loop control wrapper.
// Assumes the design sources and dpllw_regs.svh are on the include path.
`include "dpllw_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module digital_pll_control_wrapper_tb;
    import dpllw_pkg::*;
    logic i_mclk = 1'b0;
    logic i_resetn = 1'b0;
    logic [1:0] i_clock_mode_pins = 2'h3;
    logic i_idle = 1'b0;
    logic i_test_mode = 1'b0;
    logic i_core_lock_lost = 1'b0;
    logic i_ctl_wr = 1'b0;
    logic [15:0] i_ctl_wdata = 16'h0;
    wire logic [15:0] o_ctl_rdata;
    wire logic o_lock_status, o_lock_intact_flag, o_clk_tick, o_use_synth;
    wire logic o_test_clock_out, o_core_enable, o_isolation_ctrl;
    wire logic [4:0] o_core_mult;
    wire logic [1:0] o_core_div;
    dpllw_state_t o_state;
    int errors = 0;
    int n_tests = 0;
    int seed = 70;
    logic armed = 1'b0;
    logic [15:0] last_rd;
    logic [15:0] q_exp[$];

    dpllw_ctrl #(.P_STAGES(5), .P_CNT_W(11)) DUT (
        .i_mclk(i_mclk), .i_resetn(i_resetn), .i_clock_mode_pins(i_clock_mode_pins),
        .i_idle(i_idle), .i_test_mode(i_test_mode), .i_core_lock_lost(i_core_lock_lost),
        .i_ctl_wr(i_ctl_wr), .i_ctl_wdata(i_ctl_wdata), .o_ctl_rdata(o_ctl_rdata),
        .o_lock_status(o_lock_status), .o_lock_intact_flag(o_lock_intact_flag),
        .o_clk_tick(o_clk_tick), .o_use_synth(o_use_synth),
        .o_test_clock_out(o_test_clock_out), .o_core_enable(o_core_enable),
        .o_core_mult(o_core_mult), .o_core_div(o_core_div),
        .o_isolation_ctrl(o_isolation_ctrl), .o_state(o_state)
    );

    initial begin
        forever #5 i_mclk = ~i_mclk;
    end

    task automatic cmp_val(input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic cmp_reg(input logic [15:0] exp, input logic [15:0] got);
        cmp_val(exp, got);
    endtask

    task automatic close_out();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Every register change must have been announced by the driver
    always @(posedge i_mclk) begin
        if (armed && (o_ctl_rdata !== last_rd)) begin
            if (q_exp.size() == 0) begin
                cmp_reg(~o_ctl_rdata, o_ctl_rdata);
            end else begin
                cmp_reg(q_exp.pop_front(), o_ctl_rdata);
            end
        end
        last_rd <= o_ctl_rdata;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask

    task automatic wr(input logic [15:0] v, input logic note);
        if (note) q_exp.push_back((v & `DPLLW_WR_MASK & 16'hbfff) | 16'h0002);
        @(posedge i_mclk);
        i_ctl_wr <= 1'b1;
        i_ctl_wdata <= v & 16'hbfff;
        @(posedge i_mclk);
        i_ctl_wr <= 1'b0;
        #1;
    endtask

    task automatic wait_lock(input int exp_n, input int tol);
        int n;
        int t;
        n = 0;
        t = 0;
        while (o_lock_status !== 1'b1 && n < 2000) begin
            cyc(1);
            n++;
            if (o_clk_tick === 1'b1) t++;
        end
        cmp_val(16'((n >= exp_n - tol) && (n <= exp_n + tol)), 16'h1);
        cmp_val(16'(t >= n / 4 - 1), 16'h1);
    endtask

    task automatic tick_gap(output int g);
        int n;
        n = 0;
        while (o_clk_tick !== 1'b1 && n < 20) begin
            cyc(1);
            n++;
        end
        g = 0;
        do begin
            cyc(1);
            g++;
        end while (o_clk_tick !== 1'b1 && g < 20);
    endtask

    task automatic count_test(input int span, output int c);
        c = 0;
        repeat (span) begin
            cyc(1);
            if (o_test_clock_out === 1'b1) c++;
        end
    endtask

    initial begin
        #300000;
        errors++;
        close_out();
    end

    initial begin
        logic [15:0] rst_tab [4];
        logic [31:0] r;
        logic [15:0] v;
        int g;
        int m;
        int d;
        dpllw_state_t s;
        rst_tab = '{`DPLLW_RST_MODE0, `DPLLW_RST_MODE1, `DPLLW_RST_MODE2, `DPLLW_RST_MODE3};
        for (int k = 3; k >= 0; k--) begin
            @(posedge i_mclk);
            i_clock_mode_pins <= 2'(k);
            i_resetn <= 1'b0;
            repeat (5) @(posedge i_mclk);
            i_resetn <= 1'b1;
            cyc(1);
            cmp_reg(rst_tab[k], o_ctl_rdata);
            cmp_val(16'(o_state), 16'(rst_tab[k][4] ? DPLLW_ST_LOCKING : DPLLW_ST_BYPASS));
        end
        armed <= 1'b1;
        for (int b = 3; b >= 0; b--) begin
            wr(16'h2000 | 16'(b << 2), 1'b1);
            cmp_val(16'(o_state), 16'(DPLLW_ST_BYPASS));
            cmp_val({15'h0, o_lock_status}, 16'h0);
            tick_gap(g);
            cmp_val(16'(g), b[1] ? 16'h4 : (b[0] ? 16'h2 : 16'h1));
        end
        for (int k = 0; k < 3; k++) begin
            r = $random(seed);
            m = (k == 2) ? 1 : 2 + int'(r[4:0]) % 30;
            d = int'(r[6:5]);
            v = 16'h2018 | 16'(m << 7) | 16'(d << 5);
            wr(v, 1'b1);
            q_exp.push_back(v | 16'h0003);
            cmp_val(16'(o_state), 16'(DPLLW_ST_LOCKING));
            cmp_val({o_use_synth, o_lock_status, 14'h0}, 16'h0);
            wait_lock(332 * (d + 1) - 1, 3);
            cmp_val({15'h0, o_use_synth}, (m > 1) ? 16'h1 : 16'h0);
            cmp_val({11'h0, o_core_mult}, 16'(m));
            tick_gap(g);
            cmp_val(16'(g), 16'(d + 1));
            cmp_val(16'(o_state), 16'(DPLLW_ST_LOCKED));
        end
        q_exp.push_back(v);
        q_exp.push_back(v | 16'h0003);
        @(posedge i_mclk);
        i_core_lock_lost <= 1'b1;
        cyc(8);
        cmp_val(16'(o_state), 16'(DPLLW_ST_LOCKING));
        cmp_val({15'h0, o_lock_intact_flag}, 16'h0);
        i_core_lock_lost <= 1'b0;
        wait_lock(332 * (d + 1) - 4, 4);
        v = 16'h0018 | 16'(5 << 7);
        wr(v, 1'b1);
        q_exp.push_back(v | 16'h0003);
        wait_lock(331, 3);
        q_exp.push_back(v | 16'h0001);
        q_exp.push_back(v | 16'h0003);
        @(posedge i_mclk);
        i_core_lock_lost <= 1'b1;
        cyc(8);
        cmp_val({14'h0, o_state == DPLLW_ST_LOCKED, o_use_synth}, 16'h3);
        cmp_val({15'h0, o_lock_intact_flag}, 16'h0);
        i_core_lock_lost <= 1'b0;
        cyc(8);
        cmp_val({15'h0, o_lock_intact_flag}, 16'h1);
        count_test(64, g);
        cmp_val(16'(g), 16'h0);
        i_test_mode <= 1'b1;
        cyc(8);
        count_test(64, g);
        cmp_val(16'(g >= 62), 16'h1);
        wr(16'h1000 | 16'(5 << 7), 1'b1);
        count_test(320, g);
        cmp_val(16'(g >= 9 && g <= 11), 16'h1);
        wr(16'ha190, 1'b1);
        cyc(4);
        cmp_val({o_isolation_ctrl, o_core_enable, 7'h0, o_core_mult, o_core_div}, 16'h8000);
        @(posedge i_mclk);
        i_core_lock_lost <= 1'b1;
        cyc(8);
        i_core_lock_lost <= 1'b0;
        cyc(8);
        cmp_val({15'h0, o_lock_intact_flag}, 16'h1);
        wr(16'h2190, 1'b1);
        q_exp.push_back(16'h2193);
        cyc(1);
        cmp_val({o_isolation_ctrl, o_core_enable, 7'h0, o_core_mult, o_core_div}, 16'h400c);
        wait_lock(329, 4);
        armed <= 1'b0;
        i_idle <= 1'b1;
        cyc(8);
        s = o_state;
        wr(16'h2000, 1'b0);
        cmp_val(16'(o_state), 16'(s));
        i_idle <= 1'b0;
        cyc(2);
        close_out();
    end
endmodule
`default_nettype wire
